/* rtl/orpw_defs.vh */
// Contract
// - Writes only reach words of the final program memory page.
// - A word is programmed once; no erase path exists.
// - Word bits 15..8 come from data high, bits 7..0 from data low.
// - write_arm is control bit 3 and must be set before a write.
// - write_arm low inhibits writes; hardware clears it when a cycle ends.
// - write_trigger is bit 2; writing 1 starts, reads 1 while busy.
// - A trigger write is ignored unless write_arm was already set.
// - Setting arm and trigger in one write never starts a cycle.
// - Trigger must come in the access directly after the arming write.
// - The CPU is stalled for the whole write cycle.
// - Hardware clears write_trigger when the word is stored.
// - Unused control bits read 0; control and data reset to 0.
// - A table read gives low byte to software, high byte to latch.
// - The final page starts at 0F00H; the offset is added to it.
`ifndef ORPW_DEFS_VH
`define ORPW_DEFS_VH

`define ORPW_AW              5
`define ORPW_OFS_CTRL        5'h00
`define ORPW_OFS_DATA_LO     5'h04
`define ORPW_OFS_DATA_HI     5'h08
`define ORPW_OFS_TBL_PTR     5'h0C
`define ORPW_OFS_TBL_HIGH    5'h10
`define ORPW_OFS_TBL_READ    5'h14
`define ORPW_OFS_STATUS      5'h18

`define ORPW_CTRL_ARM_BIT    3
`define ORPW_CTRL_TRIG_BIT   2
`define ORPW_STAT_BUSY_BIT   0
`define ORPW_STAT_REJ_BIT    1

`define ORPW_RST_BYTE        8'h00
`define ORPW_PAGE_BASE       12'h0F00
`define ORPW_PAGE_NIBBLE     4'hF
`define ORPW_BLANK_WORD      16'h0000
`define ORPW_PROG_SUB_CYCLES 16'h0040

`endif

/* rtl/orpw_sync.v */
`default_nettype none

module orpw_sync
(
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire async_i,
  output wire rise_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;
  reg rise_q;

  // Level moves only when the two later stages agree
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end
    else
    begin
      s1_q   <= async_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      rise_q <= 1'b0;
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
        rise_q  <= s3_q & ~level_q;
      end
    end
  end

  assign rise_o = rise_q;

endmodule // orpw_sync

`default_nettype wire

/* rtl/orpw_sub_timer.v */
`default_nettype none

module orpw_sub_timer
#(
  parameter CNT_W  = 16,
  parameter CYCLES = 64
)
(
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire start_i,
  input  wire tick_i,
  output wire done_o
);

  // Cut to the counter width on purpose
  localparam integer     LAST_I = CYCLES - 1;
  localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_q;
  reg             run_q;
  reg             done_q;

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= {CNT_W{1'b0}};
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start_i)
      begin
        cnt_q <= {CNT_W{1'b0}};
        run_q <= 1'b1;
      end
      else if (run_q && tick_i)
      begin
        if (cnt_q == LAST)
        begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign done_o = done_q;

endmodule // orpw_sub_timer

`default_nettype wire

/* rtl/orpw_top.v */
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`include "orpw_defs.vh"
`default_nettype none

module orpw_top
#(
  parameter CNT_W           = 16,
  parameter PROG_SUB_CYCLES = `ORPW_PROG_SUB_CYCLES
)
(
  input  wire                 sys_clk_i,
  input  wire                 rst_i,
  input  wire [`ORPW_AW-1:0]  avs_address_i,
  input  wire                 avs_read_i,
  input  wire                 avs_write_i,
  input  wire [31:0]          avs_writedata_i,
  input  wire [3:0]           avs_byteenable_i,
  output wire [31:0]          avs_readdata_o,
  output wire                 avs_waitrequest_o,
  input  wire                 sub_clk_i,
  output wire [11:0]          otp_addr_o,
  output wire [15:0]          otp_wdata_o,
  output wire                 otp_prog_o,
  output wire                 otp_rd_o,
  input  wire [15:0]          otp_rdata_i,
  output wire                 cpu_stall_o
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WRD   = 3'h1;
  localparam [2:0] ST_WEVAL = 3'h2;
  localparam [2:0] ST_PROG  = 3'h3;
  localparam [2:0] ST_TRD   = 3'h4;
  localparam [2:0] ST_TCAPT = 3'h5;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         wait_q;
  reg  [31:0] rdata_q;
  reg  [7:0]  rd_mux;
  reg         arm_q;
  reg         trig_q;
  reg         arm_fresh_q;
  reg  [7:0]  data_lo_q;
  reg  [7:0]  data_hi_q;
  reg  [7:0]  tbl_ptr_q;
  reg  [7:0]  tbl_low_q;
  reg  [7:0]  tbl_high_q;
  reg         reject_q;
  reg  [11:0] otp_addr_q;
  reg  [15:0] otp_wdata_q;
  reg         otp_prog_q;
  reg         otp_rd_q;
  reg         stall_q;

  wire        req;
  wire        acc;
  wire        wr_acc;
  wire        lane0;
  wire        wr_ctrl;
  wire        wd_arm;
  wire        wd_trig;
  wire        start;
  wire        tbl_go;
  wire        stat_clr;
  wire        blank;
  wire        sub_tick;
  wire        prog_done;
  wire        cycle_end;
  wire        refuse;
  wire [11:0] page_addr;

  orpw_sync u_sync
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (sub_clk_i),
    .rise_o    (sub_tick)
  );

  orpw_sub_timer
  #(
    .CNT_W  (CNT_W),
    .CYCLES (PROG_SUB_CYCLES)
  )
  u_timer
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (state_q == ST_WEVAL && blank),
    .tick_i    (sub_tick),
    .done_o    (prog_done)
  );

  assign req      = avs_read_i | avs_write_i;
  assign acc      = req & ~wait_q;
  assign wr_acc   = acc & avs_write_i;
  assign lane0    = avs_byteenable_i[0];
  assign wr_ctrl  = wr_acc && lane0 && (avs_address_i == `ORPW_OFS_CTRL);
  assign wd_arm   = avs_writedata_i[`ORPW_CTRL_ARM_BIT];
  assign wd_trig  = avs_writedata_i[`ORPW_CTRL_TRIG_BIT];
  assign tbl_go   = wr_acc && (avs_address_i == `ORPW_OFS_TBL_READ);
  assign stat_clr = wr_acc && lane0 && (avs_address_i == `ORPW_OFS_STATUS)
                    && avs_writedata_i[`ORPW_STAT_REJ_BIT];

  // Arm must already be set, and by the access just before this one
  assign start = wr_ctrl && wd_trig && wd_arm && arm_q && arm_fresh_q;

  // Only the final page is ever addressed
  assign page_addr = {`ORPW_PAGE_NIBBLE, tbl_ptr_q};

  // A word that no longer reads blank has been programmed already
  assign blank = (otp_rdata_i == `ORPW_BLANK_WORD);

  assign refuse    = (state_q == ST_WEVAL) && !blank;
  assign cycle_end = ((state_q == ST_PROG) && prog_done) || refuse;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          state_d = ST_WRD;
        end
        else if (tbl_go)
        begin
          state_d = ST_TRD;
        end
      end
      ST_WRD:   state_d = ST_WEVAL;
      // A used word ends the cycle at once, with no program pulse
      ST_WEVAL: state_d = blank ? ST_PROG : ST_IDLE;
      ST_PROG:
      begin
        if (prog_done)
        begin
          state_d = ST_IDLE;
        end
      end
      ST_TRD:   state_d = ST_TCAPT;
      ST_TCAPT: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always @*
  begin
    rd_mux = `ORPW_RST_BYTE;
    case (avs_address_i)
      `ORPW_OFS_CTRL:     rd_mux = {4'h0, arm_q, trig_q, 2'h0};
      `ORPW_OFS_DATA_LO:  rd_mux = data_lo_q;
      `ORPW_OFS_DATA_HI:  rd_mux = data_hi_q;
      `ORPW_OFS_TBL_PTR:  rd_mux = tbl_ptr_q;
      `ORPW_OFS_TBL_HIGH: rd_mux = tbl_high_q;
      `ORPW_OFS_TBL_READ: rd_mux = tbl_low_q;
      `ORPW_OFS_STATUS:   rd_mux = {6'h00, reject_q, state_q != ST_IDLE};
      default:            rd_mux = `ORPW_RST_BYTE;
    endcase
  end

  // One wait cycle per access; held high while anything runs, so the CPU stalls
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (wait_q)
      begin
        if (req && state_q == ST_IDLE)
        begin
          wait_q  <= 1'b0;
          rdata_q <= {24'h00_0000, rd_mux};
        end
      end
      else
      begin
        wait_q <= 1'b1;
      end
    end
  end

  // The arming write only counts for the very next access
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      arm_fresh_q <= 1'b0;
    end
    else if (acc)
    begin
      arm_fresh_q <= wr_ctrl && wd_arm && !wd_trig;
    end
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      arm_q <= 1'b0;
    end
    else if (cycle_end)
    begin
      arm_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      arm_q <= wd_arm;
    end
  end

  // Only hardware clears the trigger; a stray 1 without arm is dropped
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig_q <= 1'b0;
    end
    else if (cycle_end)
    begin
      trig_q <= 1'b0;
    end
    else if (start)
    begin
      trig_q <= 1'b1;
    end
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_lo_q <= `ORPW_RST_BYTE;
      data_hi_q <= `ORPW_RST_BYTE;
      tbl_ptr_q <= `ORPW_RST_BYTE;
    end
    else if (wr_acc && lane0)
    begin
      if (avs_address_i == `ORPW_OFS_DATA_LO)
      begin
        data_lo_q <= avs_writedata_i[7:0];
      end
      if (avs_address_i == `ORPW_OFS_DATA_HI)
      begin
        data_hi_q <= avs_writedata_i[7:0];
      end
      if (avs_address_i == `ORPW_OFS_TBL_PTR)
      begin
        tbl_ptr_q <= avs_writedata_i[7:0];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reject_q <= 1'b0;
    end
    else if (refuse)
    begin
      reject_q <= 1'b1;
    end
    else if (stat_clr)
    begin
      reject_q <= 1'b0;
    end
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tbl_low_q  <= `ORPW_RST_BYTE;
      tbl_high_q <= `ORPW_RST_BYTE;
    end
    else if (state_q == ST_TCAPT)
    begin
      tbl_low_q  <= otp_rdata_i[7:0];
      tbl_high_q <= otp_rdata_i[15:8];
    end
  end

  // Array port: address and data are frozen for the whole cycle
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      otp_addr_q  <= 12'h000;
      otp_wdata_q <= 16'h0000;
      otp_rd_q    <= 1'b0;
      otp_prog_q  <= 1'b0;
    end
    else
    begin
      otp_rd_q <= 1'b0;
      if (state_q == ST_IDLE && (start || tbl_go))
      begin
        otp_addr_q <= page_addr;
        otp_rd_q   <= 1'b1;
        if (start)
        begin
          otp_wdata_q <= {data_hi_q, data_lo_q};
        end
      end
      if (state_q == ST_WEVAL && blank)
      begin
        otp_prog_q <= 1'b1;
      end
      else if (cycle_end)
      begin
        otp_prog_q <= 1'b0;
      end
    end
  end

  // Stall from the accepted trigger until the word is stored or refused
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stall_q <= 1'b0;
    end
    else if (start)
    begin
      stall_q <= 1'b1;
    end
    else if (cycle_end)
    begin
      stall_q <= 1'b0;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign otp_addr_o        = otp_addr_q;
  assign otp_wdata_o       = otp_wdata_q;
  assign otp_prog_o        = otp_prog_q;
  assign otp_rd_o          = otp_rd_q;
  assign cpu_stall_o       = stall_q;

endmodule // orpw_top

`default_nettype wire

/* tb/orpw_properties.sv */
`include "orpw_defs.vh"
`default_nettype none

module orpw_properties
(
  input wire logic                sys_clk_i,
  input wire logic                rst_i,
  input wire logic [`ORPW_AW-1:0] avs_address_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic [31:0]         avs_writedata_i,
  input wire logic [3:0]          avs_byteenable_i,
  input wire logic [31:0]         avs_readdata_o,
  input wire logic                avs_waitrequest_o,
  input wire logic                sub_clk_i,
  input wire logic [11:0]         otp_addr_o,
  input wire logic [15:0]         otp_wdata_o,
  input wire logic                otp_prog_o,
  input wire logic                otp_rd_o,
  input wire logic [15:0]         otp_rdata_i,
  input wire logic                cpu_stall_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_page_only: assert property (otp_prog_o |-> otp_addr_o[11:8] == `ORPW_PAGE_NIBBLE)
    else $error("program outside final page");
  a_blank_check: assert property ($rose(otp_prog_o) |-> $past(otp_rd_o, 2))
    else $error("program without blank check");
  a_word_hold: assert property (otp_prog_o && $past(otp_prog_o) |-> $stable(otp_wdata_o))
    else $error("word moved while programming");
  a_stall_prog: assert property (otp_prog_o |-> cpu_stall_o)
    else $error("program without stall");
  a_stall_start: assert property ($rose(cpu_stall_o) |-> otp_rd_o)
    else $error("stall without blank read");
  a_bus_held: assert property (cpu_stall_o |-> avs_waitrequest_o)
    else $error("access answered during stall");
  a_prog_end: assert property ($fell(otp_prog_o) |-> ##[0:3] !cpu_stall_o)
    else $error("stall outlives program");
  a_rd_pulse: assert property (otp_rd_o |=> !otp_rd_o)
    else $error("read pulse too long");
  a_ctrl_zero: assert property (!avs_waitrequest_o && avs_read_i &&
    avs_address_i == `ORPW_OFS_CTRL |-> (avs_readdata_o & 32'hFFFF_FFF3) == 32'h0000_0000)
    else $error("unused control bits set");

  c_prog: cover property ($rose(otp_prog_o));
  c_stall_end: cover property ($fell(cpu_stall_o));
  c_tbl_read: cover property (otp_rd_o && !cpu_stall_o);
endmodule // orpw_properties

`default_nettype wire

/* tb/orpw_otp_model.sv */
`default_nettype none

module orpw_otp_model
(
  input  wire logic        sys_clk_i,
  input  wire logic [11:0] otp_addr_i,
  input  wire logic [15:0] otp_wdata_i,
  input  wire logic        otp_prog_i,
  input  wire logic        otp_rd_i,
  output var  logic [15:0] otp_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem_q [0:4095];
  logic        prog_q;

  initial
  begin
    foreach (mem_q[i])
      mem_q[i] = 16'h0000;
    prog_q = 1'b0;
    otp_rdata_o = 16'hA5A5;
  end

  always @(posedge sys_clk_i)
  begin
    prog_q <= otp_prog_i;
    if (otp_rd_i)
      otp_rdata_o <= mem_q[otp_addr_i];
    else
      otp_rdata_o <= ~otp_rdata_o; // Data valid one cycle only
    if (otp_prog_i && !prog_q)
      mem_q[otp_addr_i] <= mem_q[otp_addr_i] | otp_wdata_i;
  end
endmodule // orpw_otp_model

`default_nettype wire

/* tb/otp_last_page_param_writer_tb_top.sv */
`include "orpw_defs.vh"
`default_nettype none

module otp_last_page_param_writer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        sub_clk   = 1'b0;
  logic [4:0]  adr       = 5'h00;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [3:0]  ben       = 4'h1;
  logic [31:0] wdat      = 32'h0000_0000;
  logic [31:0] q;
  wire  [31:0] rdat;
  wire         wait_w;
  wire         prog;
  wire         rdp;
  wire         stall;
  wire  [11:0] oaddr;
  wire  [15:0] owd;
  wire  [15:0] ord;
  int          miscompares = 0;
  int          comparisons = 0;

  always #25 sys_clk_i = ~sys_clk_i;
  // Free running from time zero, unrelated to the system clock
  always #190 sub_clk = ~sub_clk;

  orpw_top #(.PROG_SUB_CYCLES(2)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(ben), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_w),
    .sub_clk_i(sub_clk), .otp_addr_o(oaddr), .otp_wdata_o(owd), .otp_prog_o(prog),
    .otp_rd_o(rdp), .otp_rdata_i(ord), .cpu_stall_o(stall));

  orpw_otp_model otp_u (.sys_clk_i(sys_clk_i), .otp_addr_i(oaddr), .otp_wdata_i(owd),
    .otp_prog_i(prog), .otp_rd_i(rdp), .otp_rdata_o(ord));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h00_0000, d};
    // Held through any stall; only the watchdog ends a hang
    do
      @(posedge sys_clk_i);
    while (wait_w !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Arm then trigger in back-to-back accesses
  task automatic fire();
    acc(1'b1, `ORPW_OFS_CTRL, 8'h08);
    acc(1'b1, `ORPW_OFS_CTRL, 8'h0C);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b0, 5'(4 * i), 8'h00);
      chk("reset value", q, 32'h0000_0000);
    end
    acc(1'b1, `ORPW_OFS_DATA_LO, 8'h34);
    acc(1'b1, `ORPW_OFS_DATA_HI, 8'h12);
    acc(1'b1, `ORPW_OFS_TBL_PTR, 8'h05);
    acc(1'b0, `ORPW_OFS_DATA_HI, 8'h00);
    chk("data high", q, 32'h0000_0012);
    // No interrupt source here can split the arm-and-trigger pair
    fire();
    repeat (2) @(negedge sys_clk_i);
    chk("stall", {31'h0, stall}, 32'h0000_0001);
    acc(1'b0, `ORPW_OFS_CTRL, 8'h00);
    chk("ctrl done", q, 32'h0000_0000);
    chk("array word", {16'h0000, otp_u.mem_q[12'hF05]}, 32'h0000_1234);
    acc(1'b1, `ORPW_OFS_TBL_READ, 8'h00);
    acc(1'b0, `ORPW_OFS_TBL_READ, 8'h00);
    chk("table low", q, 32'h0000_0034);
    acc(1'b0, `ORPW_OFS_TBL_HIGH, 8'h00);
    chk("table high", q, 32'h0000_0012);
    // Second write to a used word must be refused
    acc(1'b1, `ORPW_OFS_DATA_LO, 8'h0F);
    fire();
    acc(1'b0, `ORPW_OFS_STATUS, 8'h00);
    chk("reject", q, 32'h0000_0002);
    chk("word kept", {16'h0000, otp_u.mem_q[12'hF05]}, 32'h0000_1234);
    acc(1'b1, `ORPW_OFS_STATUS, 8'h02);
    acc(1'b0, `ORPW_OFS_STATUS, 8'h00);
    chk("reject clear", q, 32'h0000_0000);
    acc(1'b1, `ORPW_OFS_TBL_PTR, 8'h06);
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, `ORPW_OFS_CTRL, (i == 2) ? 8'h08 : 8'h00);
      if (i == 2)
        acc(1'b1, `ORPW_OFS_DATA_LO, 8'h55);
      acc(1'b1, `ORPW_OFS_CTRL, (i == 1) ? 8'h04 : 8'h0C);
      acc(1'b0, `ORPW_OFS_CTRL, 8'h00);
      chk("refused ctrl", q, (i == 1) ? 32'h0000_0000 : 32'h0000_0008);
      chk("blank word", {16'h0000, otp_u.mem_q[12'hF06]}, 32'h0000_0000);
    end
    acc(1'b0, 5'h1C, 8'h00);
    chk("unmapped", q, 32'h0000_0000);
    // A write without the low byte lane must leave the register alone
    ben <= 4'h0;
    acc(1'b1, `ORPW_OFS_DATA_LO, 8'hAA);
    ben <= 4'h1;
    acc(1'b0, `ORPW_OFS_DATA_LO, 8'h00);
    chk("lane off", q, 32'h0000_0055);
    tally_and_finish();
  end
endmodule // otp_last_page_param_writer_tb_top

bind orpw_top orpw_properties chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sub_clk_i(sub_clk_i), .otp_addr_o(otp_addr_o), .otp_wdata_o(otp_wdata_o),
  .otp_prog_o(otp_prog_o), .otp_rd_o(otp_rd_o), .otp_rdata_i(otp_rdata_i),
  .cpu_stall_o(cpu_stall_o));

`default_nettype wire
